//--- logic/sbs_ctrl.sv
// command decode, burst addressing, data pipes and sleep for burst sram
//
// Operation
// - read begins at external address when selected
// - advance high continues burst, ignores selects
// - deselect continue only after deselect, bus off
// - selected write with lane enable begins write, except during recovery
// - write load with no lanes is a deselect
// - inactive chip select is power down deselect
// - read with output enable high is dummy
// - drivers off during write cycles
// - clock hold high freezes burst, read and write pipes
// - outputs high impedance at power up
// - two bit counter advances every continue
// - counter wraps after four addresses
// - linear order increments modulo four
// - interleaved order xors start with count
// - flow through low, pipelined by default
// - sleep after two cycles, recover after time
// - sleep deselects, ignores inputs, bus off
// - sleep and output enable asynchronous
// - load address low, advance counter high
// - pipelined read data one edge later
// - flow through one cycle shorter both ways
// - each lane enable writes its byte
`timescale 1ns/1ns
`include "sbs_regs.svh"
module sbs_ctrl (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic clk_hold_n,
	input wire logic advance_load,
	input wire logic write_n,
	input wire logic [3:0] byte_lane_we_n,
	input wire logic chip_sel_first_n,
	input wire logic chip_sel_second,
	input wire logic chip_sel_third_n,
	input wire logic out_en_n,
	input wire logic sleep_req,
	input wire logic burst_order_linear_n,
	input wire logic flow_thru_sel_n,
	input wire logic [18:0] addr_in,
	input wire logic [35:0] dq_in,
	output logic [35:0] dq_out,
	output logic dq_oe,
	output logic sleep_active,
	output sbs_pkg::sbs_mem_wr_s mem_wr,
	output logic mem_wr_valid,
	input wire logic mem_wr_ready,
	output logic [18:0] mem_rd_addr,
	input wire logic [35:0] mem_rd_data
);
	import sbs_pkg::*;

	// ----------------------------------------
	// asynchronous pins through three flops
	// ----------------------------------------
	// sleep and output enable are caught in three stages; a change counts
	// once the last two agree, so a glitch on the pin never moves state
	logic [2:0] slp_sync_r;
	logic [2:0] oe_sync_r;
	logic slp_lvl_r;
	logic oen_lvl_r;
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			slp_sync_r <= 3'h0;
			oe_sync_r <= 3'h7;
			slp_lvl_r <= 1'b0;
			oen_lvl_r <= 1'b1;
		end else begin
			slp_sync_r <= {slp_sync_r[1:0], sleep_req};
			oe_sync_r <= {oe_sync_r[1:0], out_en_n};
			if (slp_sync_r[2] == slp_sync_r[1])
				slp_lvl_r <= slp_sync_r[2];
			if (oe_sync_r[2] == oe_sync_r[1])
				oen_lvl_r <= oe_sync_r[2];
		end
	end

	// ----------------------------------------
	// sleep sequencing
	// ----------------------------------------
	localparam logic [7:0] ENTRY_CYC = 8'(`SBS_SLEEP_ENTRY_CYC);
	localparam logic [7:0] RECOV_CYC = 8'(`SBS_SLEEP_RECOVERY_CYC);
	// the request is seen only through the level flop, so a short pulse
	// on the pin never starts an entry
	sbs_pw_e pw_r, pw_nxt;
	logic [7:0] pw_cnt_r, pw_cnt_nxt;
	always_comb begin
		pw_nxt = pw_r;
		pw_cnt_nxt = pw_cnt_r;
		case (pw_r)
			SBS_PW_AWAKE: begin
				if (slp_lvl_r) begin
					pw_nxt = SBS_PW_ENTER;
					pw_cnt_nxt = 8'h1;
				end
			end
			SBS_PW_ENTER: begin
				if (!slp_lvl_r)
					pw_nxt = SBS_PW_AWAKE;
				else if (pw_cnt_r >= ENTRY_CYC)
					pw_nxt = SBS_PW_SLEEP;
				else
					pw_cnt_nxt = pw_cnt_r + 8'h1;
			end
			SBS_PW_SLEEP: begin
				if (!slp_lvl_r) begin
					pw_nxt = SBS_PW_RECOVER;
					pw_cnt_nxt = 8'h1;
				end
			end
			SBS_PW_RECOVER: begin
				if (slp_lvl_r)
					pw_nxt = SBS_PW_SLEEP;
				else if (pw_cnt_r >= RECOV_CYC)
					pw_nxt = SBS_PW_AWAKE;
				else
					pw_cnt_nxt = pw_cnt_r + 8'h1;
			end
			default: pw_nxt = SBS_PW_AWAKE;
		endcase
	end
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			pw_r <= SBS_PW_AWAKE;
			pw_cnt_r <= 8'h0;
		end else begin
			pw_r <= pw_nxt;
			pw_cnt_r <= pw_cnt_nxt;
		end
	end
	wire asleep = (pw_r == SBS_PW_SLEEP);
	wire recovering = (pw_r == SBS_PW_RECOVER);

	// ----------------------------------------
	// command decode
	// ----------------------------------------
	wire selected = !chip_sel_first_n && chip_sel_second
		&& !chip_sel_third_n;
	wire any_lane = ~&byte_lane_we_n;
	wire edge_live = !clk_hold_n && !asleep;
	wire is_load = edge_live && !advance_load;
	wire is_cont = edge_live && advance_load;
	wire ld_read = is_load && selected && write_n;
	// write loads during recovery are refused; the host keeps to reads there
	wire ld_write = is_load && selected && !write_n && any_lane
		&& !recovering;
	wire ld_desel = is_load && !ld_read && !ld_write;
	// a load outside the select or with no lanes opens a deselect burst,
	// so the continues that follow stay off the bus
	sbs_cmd_e burst_kind_r;
	// continuation repeats the kind of the burst that was loaded
	wire cont_read = is_cont && burst_kind_r == SBS_CMD_READ;
	wire cont_write = is_cont && burst_kind_r == SBS_CMD_WRITE
		&& any_lane;
	// a continue after a deselect stays deselected, bus off
	wire cont_desel = is_cont && burst_kind_r == SBS_CMD_DESEL;

	// ----------------------------------------
	// burst address counter
	// ----------------------------------------
	logic [18:0] base_r;
	logic [1:0] bcnt_r;
	wire [1:0] bcnt_step = bcnt_r + 2'h1;
	wire [1:0] lin_lo = base_r[1:0] + bcnt_step;
	wire [1:0] ilv_lo = base_r[1:0] ^ bcnt_step;
	wire [1:0] next_lo = burst_order_linear_n ? ilv_lo : lin_lo;
	wire [18:0] next_addr = {base_r[18:2], next_lo};
	wire [18:0] acc_addr = is_load ? addr_in : next_addr;
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			base_r <= 19'h0;
			bcnt_r <= `SBS_BCNT_RST;
			burst_kind_r <= SBS_CMD_DESEL;
		end else if (is_load) begin
			base_r <= addr_in;
			bcnt_r <= `SBS_BCNT_RST;
			burst_kind_r <= ld_desel ? SBS_CMD_DESEL :
				ld_read ? SBS_CMD_READ : SBS_CMD_WRITE;
		end else if (is_cont) begin
			bcnt_r <= bcnt_step;
		end
	end
	// the array is read in the command cycle, so this address is the one
	// output that cannot come from a flop
	assign mem_rd_addr = acc_addr;

	// ----------------------------------------
	// read data path
	// ----------------------------------------
	// stage 1 holds the word read at the command edge; in pipelined mode
	// it moves to stage 2 one edge later
	logic rd1_r, rd2_r;
	logic [35:0] rd1_d_r;
	logic [35:0] rd2_d_r;
	logic [35:0] dq_out_r;
	logic dq_oe_r;
	logic wr_busy;
	wire pipe_mode = flow_thru_sel_n;
	wire rd_now = ld_read || cont_read;
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			rd1_r <= 1'b0;
			rd2_r <= 1'b0;
			rd1_d_r <= 36'h0;
			rd2_d_r <= 36'h0;
		end else if (!clk_hold_n) begin
			rd1_r <= rd_now;
			rd1_d_r <= mem_rd_data;
			rd2_r <= rd1_r && pipe_mode;
			rd2_d_r <= rd1_d_r;
		end
	end
	// flow-through feeds the output flop from stage 1, pipelined from
	// stage 2; the output flop adds the one edge both modes share
	wire [35:0] drv_data = pipe_mode ? rd2_d_r : rd1_d_r;
	wire drv_want = pipe_mode ? rd2_r : rd1_r;
	// write phases keep drivers off even with output enable tied low
	wire drv_ok = drv_want && !oen_lvl_r && !wr_busy && !asleep
		&& pw_r != SBS_PW_ENTER;
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			dq_out_r <= 36'h0;
			dq_oe_r <= 1'b0;
		end else begin
			if (!clk_hold_n && drv_want)
				dq_out_r <= drv_data;
			dq_oe_r <= drv_ok;
		end
	end
	assign dq_out = dq_out_r;
	assign dq_oe = dq_oe_r;

	// ----------------------------------------
	// late write pipe
	// ----------------------------------------
	sbs_wr_s wp1_r, wp2_r;
	logic wv1_r, wv2_r;
	wire wr_now = ld_write || cont_write;
	wire wr_due = pipe_mode ? wv2_r : wv1_r;
	wire sbs_wr_s wr_due_s = pipe_mode ? wp2_r : wp1_r;
	assign wr_busy = wv1_r || wv2_r;
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			wv1_r <= 1'b0;
			wv2_r <= 1'b0;
			wp1_r <= '0;
			wp2_r <= '0;
		end else if (!clk_hold_n) begin
			wv1_r <= wr_now;
			wp1_r <= '{addr: acc_addr, lane_we: ~byte_lane_we_n};
			wv2_r <= wv1_r && pipe_mode;
			wp2_r <= wp1_r;
		end
	end

	// two-entry buffer toward the memory array; a stall there holds words
	// a full buffer still takes a word when its head leaves in that cycle;
	// the host has no back-pressure, so a stall that outlasts the two
	// entries drops the late word
	logic [1:0] fcnt_r;
	logic fq_vld_r;
	sbs_mem_wr_s fq_r [2];
	wire pop = fq_vld_r && mem_wr_ready;
	wire push = wr_due && !clk_hold_n && (fcnt_r != 2'h2 || pop);
	wire [1:0] fcnt_nxt = fcnt_r + {1'b0, push} - {1'b0, pop};
	// the new word lands behind whatever stays after this cycle's pop
	wire fq_wi = pop ? fcnt_r[1] : fcnt_r[0];
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			fcnt_r <= 2'h0;
			fq_vld_r <= 1'b0;
			fq_r[0] <= '0;
			fq_r[1] <= '0;
		end else begin
			if (pop)
				fq_r[0] <= fq_r[1];
			if (push)
				fq_r[fq_wi] <=
					'{addr: wr_due_s.addr, data: dq_in,
					lane_we: wr_due_s.lane_we};
			fcnt_r <= fcnt_nxt;
			fq_vld_r <= fcnt_nxt != 2'h0;
		end
	end
	assign mem_wr = fq_r[0];
	assign mem_wr_valid = fq_vld_r;

	// ----------------------------------------
	// status
	// ----------------------------------------
	// status follows the next state, so it rises on the entry edge itself
	logic sleep_r;
	always_ff @(posedge clk_sys) begin
		if (!nrst)
			sleep_r <= 1'b0;
		else
			sleep_r <= pw_nxt == SBS_PW_SLEEP;
	end
	assign sleep_active = sleep_r;
endmodule : sbs_ctrl

//--- logic/sbs_pkg.sv
// types shared by the burst sram control block
package sbs_pkg;
	typedef enum logic [1:0] {
		SBS_CMD_DESEL = 2'b00,
		SBS_CMD_READ = 2'b01,
		SBS_CMD_WRITE = 2'b10,
		SBS_CMD_BURST = 2'b11
	} sbs_cmd_e;
	typedef enum logic [1:0] {
		SBS_PW_AWAKE = 2'b00,
		SBS_PW_ENTER = 2'b01,
		SBS_PW_SLEEP = 2'b10,
		SBS_PW_RECOVER = 2'b11
	} sbs_pw_e;
	typedef struct packed {
		logic [18:0] addr;
		logic [3:0] lane_we;
	} sbs_wr_s;
	typedef struct packed {
		logic [18:0] addr;
		logic [35:0] data;
		logic [3:0] lane_we;
	} sbs_mem_wr_s;
endpackage : sbs_pkg

//--- logic/sbs_regs.svh
// timing counts and reset values for the burst sram control block
`ifndef SBS_REGS_SVH
`define SBS_REGS_SVH
`define SBS_ADDR_W 19
`define SBS_DATA_W 36
`define SBS_LANES 4
`define SBS_LANE_W 9
`define SBS_CLK_PERIOD_NS 4
`define SBS_SLEEP_ENTRY_CYC 2
`define SBS_SLEEP_RECOVERY_TIME_NS 40
`define SBS_SLEEP_RECOVERY_CYC ((`SBS_SLEEP_RECOVERY_TIME_NS + `SBS_CLK_PERIOD_NS - 1) / `SBS_CLK_PERIOD_NS)
`define SBS_BCNT_RST 2'h0
`endif

//--- tb/sbs_ctrl_sva.sv
// port assertions for the burst sram control block
`timescale 1ns/1ns
module sbs_ctrl_chk (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic clk_hold_n,
	input wire logic out_en_n,
	input wire logic sleep_req,
	input wire logic [35:0] dq_out,
	input wire logic dq_oe,
	input wire logic sleep_active,
	input wire sbs_pkg::sbs_mem_wr_s mem_wr,
	input wire logic mem_wr_valid,
	input wire logic mem_wr_ready
);
	import sbs_pkg::*;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	rst_quiet_a: assert property (
		$past(!nrst) |-> !dq_oe && !sleep_active && !mem_wr_valid)
		else $error("outputs active after reset");
	// slack of six covers the three sync flops, the level flop and the output flop
	oe_off_a: assert property (out_en_n [*6] |-> !dq_oe)
		else $error("drivers on with output enable high");
	sleep_in_a: assert property (sleep_req [*8] |-> sleep_active)
		else $error("sleep not entered");
	sleep_off_a: assert property (sleep_active |-> !dq_oe)
		else $error("drivers on in sleep");
	hold_frz_a: assert property (
		$past(clk_hold_n) && $past(nrst) |-> $stable(dq_out))
		else $error("read data moved under clock hold");
	buf_keep_a: assert property (
		mem_wr_valid && !mem_wr_ready |=> mem_wr_valid && $stable(mem_wr))
		else $error("buffered write lost under stall");
	lanes_some_a: assert property (
		mem_wr_valid |-> mem_wr.lane_we != 4'h0)
		else $error("write pushed with no lanes");
	sleep_wr_a: assert property (
		sleep_active && !mem_wr_valid |=> !mem_wr_valid)
		else $error("write started in sleep");
endmodule : sbs_ctrl_chk
bind sbs_ctrl sbs_ctrl_chk u_chk (.clk_sys(clk_sys), .nrst(nrst),
	.clk_hold_n(clk_hold_n), .out_en_n(out_en_n), .sleep_req(sleep_req),
	.dq_out(dq_out), .dq_oe(dq_oe), .sleep_active(sleep_active),
	.mem_wr(mem_wr), .mem_wr_valid(mem_wr_valid),
	.mem_wr_ready(mem_wr_ready));

//--- tb/sbs_ctrl_tb.sv
// self-checking bench for the burst sram control block
`timescale 1ns/1ns
module sbs_ctrl_tb;
	import sbs_pkg::*;
	logic clk_sys, nrst, clk_hold_n, advance_load, write_n, chip_sel_first_n;
	logic chip_sel_second, chip_sel_third_n, out_en_n, sleep_req, stall;
	logic burst_order_linear_n, flow_thru_sel_n, dq_oe, sleep_active;
	logic mem_wr_valid, mem_wr_ready;
	logic [3:0] byte_lane_we_n;
	logic [18:0] addr_in, mem_rd_addr;
	logic [35:0] dq_in, dq_out, mem_rd_data;
	logic [35:0] cap [$];
	sbs_mem_wr_s mem_wr;
	int fails, n_compared, lat;
	sbs_ctrl uut (.clk_sys(clk_sys), .nrst(nrst), .clk_hold_n(clk_hold_n),
		.advance_load(advance_load), .write_n(write_n),
		.byte_lane_we_n(byte_lane_we_n),
		.chip_sel_first_n(chip_sel_first_n),
		.chip_sel_second(chip_sel_second),
		.chip_sel_third_n(chip_sel_third_n), .out_en_n(out_en_n),
		.sleep_req(sleep_req),
		.burst_order_linear_n(burst_order_linear_n),
		.flow_thru_sel_n(flow_thru_sel_n), .addr_in(addr_in),
		.dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
		.sleep_active(sleep_active), .mem_wr(mem_wr),
		.mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready),
		.mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data));
	sbs_mem_model mm (.clk_sys(clk_sys), .stall(stall), .mem_wr(mem_wr),
		.mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready),
		.mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data));
	initial begin
		clk_sys = 0;
		forever #2 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) if (dq_oe === 1'b1) cap.push_back(dq_out);
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task chk(input logic [35:0] got, input logic [35:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task final_report;
		if (fails == 0 && n_compared > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : final_report
	function logic [18:0] ba(input int m, input int i);
		ba = {15'h0, m[1:0], m[0] ? 2'(1 ^ i) : 2'(1 + i)};
	endfunction : ba
	// load at start 1, then n-1 continues, then deselect
	task burst(input int m, input int wr, input int n, input logic [3:0] ln);
		for (int k = 0; k < n + 3; k++) begin
			@(posedge clk_sys);
			chip_sel_first_n <= k >= n;
			advance_load <= k > 0 && k < n;
			write_n <= !wr;
			byte_lane_we_n <= ln;
			addr_in <= ba(m, 0);
			stall <= k < 3;
			if (wr && k >= lat && k - lat < n)
				dq_in <= {13'h0d2d, ln, ba(m, k - lat)};
			else dq_in <= ~dq_in;
		end
	endtask : burst
	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		{nrst, clk_hold_n, advance_load, out_en_n, sleep_req, stall} = 6'h0;
		{write_n, chip_sel_first_n, chip_sel_second} = 3'h7;
		{chip_sel_third_n, burst_order_linear_n, flow_thru_sel_n} = 3'h0;
		{byte_lane_we_n, addr_in, dq_in} = {4'hf, 19'h0, 36'h0};
		{fails, n_compared, lat} = 0;
		repeat (12) @(posedge clk_sys);
		nrst <= 1;
		#1 chk({dq_oe, sleep_active, mem_wr_valid}, 0);
		for (int m = 0; m < 4; m++) begin
			@(posedge clk_sys);
			burst_order_linear_n <= m[0];
			flow_thru_sel_n <= m[1];
			lat = 1 + m[1];
			cap.delete();
			repeat (2) @(posedge clk_sys);
			burst(m, 1, 4, 4'h0);
			repeat (6) @(posedge clk_sys);
			#1 chk(cap.size(), 0);
			for (int i = 0; i < 4; i++)
				chk(mm.mem[ba(m, i)], {17'h0d2d0, ba(m, i)});
			burst(m, 0, 5, 4'hf);
			repeat (4) @(posedge clk_sys);
			#1 chk(cap.size(), 5);
			for (int i = 0; i < 5; i++)
				chk(cap[i], {17'h0d2d0, ba(m, i % 4)});
		end
		cap.delete();
		burst(0, 1, 1, 4'hf);
		repeat (4) @(posedge clk_sys);
		#1 chk(mm.mem[1], {17'h0d2d0, ba(0, 0)});
		burst(0, 1, 1, 4'hb);
		repeat (4) @(posedge clk_sys);
		#1 chk(mm.mem[1], {13'h0d2d, 4'hb, ba(0, 0)});
		@(posedge clk_sys);
		out_en_n <= 1;
		repeat (6) @(posedge clk_sys);
		burst(0, 0, 4, 4'hf);
		repeat (4) @(posedge clk_sys);
		#1 chk(cap.size(), 0);
		@(posedge clk_sys);
		out_en_n <= 0;
		chip_sel_second <= 0;
		repeat (6) @(posedge clk_sys);
		burst(0, 0, 2, 4'hf);
		repeat (4) @(posedge clk_sys);
		#1 chk(cap.size(), 0);
		@(posedge clk_sys);
		chip_sel_second <= 1;
		clk_hold_n <= 1;
		burst(0, 0, 2, 4'hf);
		@(posedge clk_sys);
		#1 chk(cap.size(), 0);
		@(posedge clk_sys);
		clk_hold_n <= 0;
		sleep_req <= 1;
		repeat (10) @(posedge clk_sys);
		#1 chk(sleep_active, 1);
		burst(0, 0, 2, 4'hf);
		#1 chk(cap.size(), 0);
		@(posedge clk_sys);
		sleep_req <= 0;
		repeat (24) @(posedge clk_sys);
		#1 chk(sleep_active, 0);
		burst(0, 0, 1, 4'hf);
		repeat (4) @(posedge clk_sys);
		#1 chk(cap[0], {13'h0d2d, 4'hb, ba(0, 0)});
		final_report();
	end
	// whole run is under two thousand cycles
	initial begin
		#20000;
		fails++;
		final_report();
	end
endmodule : sbs_ctrl_tb

//--- tb/sbs_mem_model.sv
// memory array model behind the control block, with a stall input
`timescale 1ns/1ns
module sbs_mem_model (
	input wire logic clk_sys,
	input wire logic stall,
	input wire sbs_pkg::sbs_mem_wr_s mem_wr,
	input wire logic mem_wr_valid,
	output logic mem_wr_ready,
	input wire logic [18:0] mem_rd_addr,
	output logic [35:0] mem_rd_data
);
	import sbs_pkg::*;
	// only sixteen words: the bench keeps its addresses below 16
	logic [35:0] mem [0:15];
	assign mem_wr_ready = !stall;
	assign mem_rd_data = mem[mem_rd_addr[3:0]];
	always @(posedge clk_sys) begin
		if (mem_wr_valid && !stall) begin
			for (int i = 0; i < 4; i++) begin
				if (mem_wr.lane_we[i]) begin
					mem[mem_wr.addr[3:0]][i*9 +: 9] <=
						mem_wr.data[i*9 +: 9];
				end
			end
		end
	end
endmodule : sbs_mem_model
